// ### bfb_pkg.sv
// Shared constants for the boolean function block library
package bfb_pkg;
  localparam int unsigned GATE_N     = 3;
  localparam int unsigned XOR_N      = 2;
  localparam int unsigned MARK_N     = 8;
  localparam logic [7:0]  MARK_RST   = 8'h80;
  localparam int unsigned BLK_MAX    = 56;
  localparam int unsigned BLK_W      = 6;
  localparam int unsigned MEM_W      = 8;
  localparam int unsigned MEM_SPACE  = 48;
  localparam int unsigned NUM_EXP    = 4;
  localparam int unsigned CNT_W      = 4;
  localparam int unsigned IDX_W      = 7;
  localparam int unsigned BASE_DI    = 8;
  localparam int unsigned BASE_DQ    = 4;
  localparam int unsigned BASE_AI    = 2;
  localparam int unsigned AI_SEL_MAX = 8;
  localparam int unsigned AI_W       = 10;
  localparam int unsigned DI_AI1_BIT = 6;
  localparam int unsigned DI_AI2_BIT = 7;
  localparam logic [2:0]  PREV_RST   = 3'h0;
  localparam logic        OUT_RST    = 1'b0;
endpackage

// ### bfb_core.sv
// Boolean function blocks, markers, constants, block budget and terminal numbering
`timescale 1ns/1ps
`default_nettype none

// How it works
// - AND output high only when all inputs high.
// - Unconnected AND or NAND inputs read as high.
// - Unconnected OR, NOR or XOR inputs read as low.
// - Rising AND pulses when all high now, some low last cycle.
// - NAND output low only when all inputs high.
// - Falling NAND high when some low now, all high last cycle.
// - OR output high when any input high.
// - NOR high only when all low; drops on any rising input.
// - Two-input XOR high when inputs differ.
// - NOT outputs the complement of its single input.
// - Eight marker bits whose outputs follow their written inputs.
// - Marker outputs show last cycle's value, steady within a cycle.
// - Eighth marker high in first cycle, then behaves normally.
// - Constant sources give fixed high and fixed low.
// - Refuse new blocks at 56 or when memory need exceeds free.
// - Digital indices numbered base first, then modules in install order.
// - Base inputs seven and eight read digital or analog by use.
// - Module analog inputs numbered after existing; only 1 to 8 selectable.
module bfb_core
  import bfb_pkg::*;
#(
  parameter int unsigned  BLOCKS_MAX  = BLK_MAX,
  parameter logic [7:0]   MEM_TOTAL   = 8'(MEM_SPACE),
  parameter int unsigned  EXP_N       = NUM_EXP,
  parameter bit           BASE_ANALOG = 1'b1
) (
  // Program cycle clock and program start
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Conjunction family inputs and connection masks
  input  wire logic [GATE_N-1:0]        and_in,
  input  wire logic [GATE_N-1:0]        and_conn,
  input  wire logic [GATE_N-1:0]        andr_in,
  input  wire logic [GATE_N-1:0]        andr_conn,
  input  wire logic [GATE_N-1:0]        nand_in,
  input  wire logic [GATE_N-1:0]        nand_conn,
  input  wire logic [GATE_N-1:0]        nandf_in,
  input  wire logic [GATE_N-1:0]        nandf_conn,
  // Disjunction family inputs and connection masks
  input  wire logic [GATE_N-1:0]        or_in,
  input  wire logic [GATE_N-1:0]        or_conn,
  input  wire logic [GATE_N-1:0]        nor_in,
  input  wire logic [GATE_N-1:0]        nor_conn,
  input  wire logic [XOR_N-1:0]         xor_in,
  input  wire logic [XOR_N-1:0]         xor_conn,
  input  wire logic                     not_in,
  // Gate results, one cycle after evaluation
  output logic                          and_q,
  output logic                          and_rise_q,
  output logic                          nand_q,
  output logic                          nand_fall_q,
  output logic                          or_q,
  output logic                          nor_q,
  output logic                          xor_q,
  output logic                          not_q,
  // Constant sources
  output logic                          const_high,
  output logic                          const_low,
  // Marker bits
  input  wire logic [MARK_N-1:0]        mark_in,
  output logic [MARK_N-1:0]             mark_q,
  output logic                          first_cycle_marker,
  // Block budget
  input  wire logic                     add_req,
  input  wire logic [MEM_W-1:0]         add_need,
  output logic                          add_offer,
  output logic                          add_done_q,
  output logic                          add_refused_q,
  output logic [BLK_W-1:0]              blk_count_q,
  output logic [MEM_W-1:0]              mem_free_q,
  // Expansion module terminal counts, install order
  input  wire logic [EXP_N*CNT_W-1:0]   exp_di_cnt,
  input  wire logic [EXP_N*CNT_W-1:0]   exp_dq_cnt,
  input  wire logic [EXP_N*CNT_W-1:0]   exp_ai_cnt,
  output logic [EXP_N*IDX_W-1:0]        di_first_q,
  output logic [EXP_N*IDX_W-1:0]        dq_first_q,
  output logic [EXP_N*IDX_W-1:0]        ai_first_q,
  output logic [IDX_W-1:0]              ai_total_q,
  // Base unit inputs and analog selection
  input  wire logic [BASE_DI-1:0]       base_pin,
  input  wire logic                     prog_ai1_use,
  input  wire logic                     prog_ai2_use,
  input  wire logic [AI_W-1:0]          adc_ai1,
  input  wire logic [AI_W-1:0]          adc_ai2,
  output logic [BASE_DI-1:0]            base_di_q,
  output logic [AI_W-1:0]               analog_in1_q,
  output logic [AI_W-1:0]               analog_in2_q,
  input  wire logic [IDX_W-1:0]         ai_sel_idx,
  output logic                          ai_sel_ok
);

  // Open pins take the family default level
  function automatic logic [GATE_N-1:0] eff(input logic [GATE_N-1:0] v,
                                            input logic [GATE_N-1:0] c,
                                            input logic              dflt);
    eff = (v & c) | (~c & {GATE_N{dflt}});
  endfunction

  wire logic [GATE_N-1:0] and_e;
  wire logic [GATE_N-1:0] andr_e;
  wire logic [GATE_N-1:0] nand_e;
  wire logic [GATE_N-1:0] nandf_e;
  wire logic [GATE_N-1:0] or_e;
  wire logic [GATE_N-1:0] nor_e;
  wire logic [XOR_N-1:0]  xor_e;
  wire logic              andr_all;
  wire logic              nandf_all;
  logic [GATE_N-1:0]      andr_prev_q;
  logic [GATE_N-1:0]      nandf_prev_q;

  assign and_e   = eff(and_in, and_conn, 1'b1);
  assign andr_e  = eff(andr_in, andr_conn, 1'b1);
  assign nand_e  = eff(nand_in, nand_conn, 1'b1);
  assign nandf_e = eff(nandf_in, nandf_conn, 1'b1);
  assign or_e    = eff(or_in, or_conn, 1'b0);
  assign nor_e   = eff(nor_in, nor_conn, 1'b0);
  assign xor_e   = xor_in & xor_conn;
  assign andr_all  = &andr_e;
  assign nandf_all = &nandf_e;

  // Previous-cycle inputs for the edge blocks; reset reads as not all high
  always_ff @(posedge clock) begin
    if (rst) begin
      andr_prev_q  <= PREV_RST;
      nandf_prev_q <= PREV_RST;
    end else begin
      andr_prev_q  <= andr_e;
      nandf_prev_q <= nandf_e;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      and_q       <= OUT_RST;
      and_rise_q  <= OUT_RST;
      nand_q      <= OUT_RST;
      nand_fall_q <= OUT_RST;
      or_q        <= OUT_RST;
      nor_q       <= OUT_RST;
      xor_q       <= OUT_RST;
      not_q       <= OUT_RST;
    end else begin
      and_q       <= &and_e;
      and_rise_q  <= andr_all & ~(&andr_prev_q);
      nand_q      <= ~(&nand_e);
      nand_fall_q <= ~nandf_all & (&nandf_prev_q);
      or_q        <= |or_e;
      nor_q       <= ~(|nor_e);
      xor_q       <= xor_e[0] ^ xor_e[1];
      not_q       <= ~not_in;
    end
  end

  assign const_high = 1'b1;
  assign const_low  = 1'b0;

  // Reset value preloads the eighth marker for the first cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      mark_q <= MARK_RST;
    end else begin
      mark_q <= mark_in;
    end
  end

  logic first_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end
  assign first_cycle_marker = first_q;

  // Block budget: removal only by a new program start
  wire logic room_blk;
  wire logic room_mem;
  assign room_blk  = blk_count_q < BLK_W'(BLOCKS_MAX);
  assign room_mem  = add_need <= mem_free_q;
  assign add_offer = room_blk & room_mem;

  always_ff @(posedge clock) begin
    if (rst) begin
      blk_count_q   <= '0;
      mem_free_q    <= MEM_TOTAL;
      add_done_q    <= 1'b0;
      add_refused_q <= 1'b0;
    end else begin
      add_done_q    <= add_req & add_offer;
      add_refused_q <= add_req & ~add_offer;
      if (add_req && add_offer) begin
        blk_count_q <= blk_count_q + 1'b1;
        mem_free_q  <= mem_free_q - add_need;
      end
    end
  end

  // Terminal numbering as running sums over install order
  logic [EXP_N*IDX_W-1:0] di_first_d;
  logic [EXP_N*IDX_W-1:0] dq_first_d;
  logic [EXP_N*IDX_W-1:0] ai_first_d;
  logic [IDX_W-1:0]       ai_total_d;
  always_comb begin
    logic [IDX_W-1:0] di_n;
    logic [IDX_W-1:0] dq_n;
    logic [IDX_W-1:0] ai_n;
    di_n = IDX_W'(BASE_DI + 1);
    dq_n = IDX_W'(BASE_DQ + 1);
    ai_n = BASE_ANALOG ? IDX_W'(BASE_AI + 1) : IDX_W'(1);
    for (int i = 0; i < EXP_N; i++) begin
      di_first_d[i*IDX_W +: IDX_W] = di_n;
      dq_first_d[i*IDX_W +: IDX_W] = dq_n;
      ai_first_d[i*IDX_W +: IDX_W] = ai_n;
      di_n = di_n + IDX_W'(exp_di_cnt[i*CNT_W +: CNT_W]);
      dq_n = dq_n + IDX_W'(exp_dq_cnt[i*CNT_W +: CNT_W]);
      ai_n = ai_n + IDX_W'(exp_ai_cnt[i*CNT_W +: CNT_W]);
    end
    ai_total_d = ai_n - 1'b1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      di_first_q <= '0;
      dq_first_q <= '0;
      ai_first_q <= '0;
      ai_total_q <= '0;
    end else begin
      di_first_q <= di_first_d;
      dq_first_q <= dq_first_d;
      ai_first_q <= ai_first_d;
      ai_total_q <= ai_total_d;
    end
  end

  // Only channels one to eight that exist may feed analog functions
  assign ai_sel_ok = (ai_sel_idx != '0) && (ai_sel_idx <= IDX_W'(AI_SEL_MAX))
                     && (ai_sel_idx <= ai_total_q);

  // Base pins are asynchronous, two flops before use
  logic [BASE_DI-1:0] pin_s1_q;
  logic [BASE_DI-1:0] pin_s2_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= base_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire logic ai1_used;
  wire logic ai2_used;
  logic [BASE_DI-1:0] di_mask;
  assign ai1_used = BASE_ANALOG & prog_ai1_use;
  assign ai2_used = BASE_ANALOG & prog_ai2_use;
  always_comb begin
    di_mask             = '1;
    di_mask[DI_AI1_BIT] = ~ai1_used;
    di_mask[DI_AI2_BIT] = ~ai2_used;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      base_di_q    <= '0;
      analog_in1_q <= '0;
      analog_in2_q <= '0;
    end else begin
      base_di_q    <= pin_s2_q & di_mask;
      analog_in1_q <= ai1_used ? adc_ai1 : '0;
      analog_in2_q <= ai2_used ? adc_ai2 : '0;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  and_value_a: assert property (
    1'b1 |=> (and_q == &$past(and_e))) else $error("and output wrong");
  and_open_a: assert property (
    (and_conn == '0) |=> and_q) else $error("open and inputs not high");
  or_open_a: assert property (
    (or_conn == '0) |=> !or_q) else $error("open or inputs not low");
  rise_single_a: assert property (
    and_rise_q |=> !and_rise_q) else $error("rising and pulse too long");
  nand_value_a: assert property (
    1'b1 |=> (nand_q != &$past(nand_e))) else $error("nand output wrong");
  fall_cause_a: assert property (
    nand_fall_q |-> (!$past(nandf_all) && $past(nandf_all, 2)))
    else $error("falling nand without cause");
  or_value_a: assert property (
    (|or_e) |=> or_q) else $error("or output low with high input");
  nor_drop_a: assert property (
    $rose(|nor_e) |=> !nor_q) else $error("nor did not drop");
  xor_value_a: assert property (
    (xor_e[0] != xor_e[1]) |=> xor_q) else $error("xor output wrong");
  not_value_a: assert property (
    not_in |=> !not_q) else $error("not output wrong");
  mark_follow_a: assert property (
    1'b1 |=> (mark_q == $past(mark_in))) else $error("marker did not follow");
  sequence first_cycle_s;
    (mark_q == MARK_RST) && first_cycle_marker;
  endsequence
  sequence marker_clear_s;
    !first_cycle_marker;
  endsequence
  first_mark_a: assert property (
    $fell(rst) |-> first_cycle_s ##1 marker_clear_s)
    else $error("first cycle marker wrong");
  blk_full_a: assert property (
    (add_req && blk_count_q == BLK_W'(BLOCKS_MAX)) |=> add_refused_q && $stable(blk_count_q))
    else $error("block added beyond limit");
  ai_sel_a: assert property (
    (ai_sel_idx > IDX_W'(AI_SEL_MAX)) |-> !ai_sel_ok) else $error("analog index above eight");

endmodule

`default_nettype wire

// ### boolean_function_blocks_tb_top.sv
// Self-checking testbench for the boolean function block core
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); err_count++; end end

module boolean_function_blocks_tb_top;
  import bfb_pkg::*;

  logic                   clock = 1'b0;
  logic                   rst = 1'b1;
  logic [GATE_N-1:0]      and_in = '0, and_conn = '1, andr_in = '0, andr_conn = '1;
  logic [GATE_N-1:0]      nand_in = '0, nand_conn = '1, nandf_in = '0, nandf_conn = '1;
  logic [GATE_N-1:0]      or_in = '0, or_conn = '1, nor_in = '0, nor_conn = '1;
  logic [XOR_N-1:0]       xor_in = '0, xor_conn = '1;
  logic                   not_in = 1'b0;
  logic                   and_q, and_rise_q, nand_q, nand_fall_q, or_q, nor_q, xor_q, not_q;
  logic                   const_high, const_low, first_cycle_marker;
  logic [MARK_N-1:0]      mark_in = '0, mark_q;
  logic                   add_req = 1'b0, add_offer, add_done_q, add_refused_q;
  logic [MEM_W-1:0]       add_need = '0, mem_free_q;
  logic [BLK_W-1:0]       blk_count_q;
  // Module 0 sits in the low nibble
  logic [4*CNT_W-1:0]     exp_di_cnt = 16'h1234, exp_dq_cnt = 16'h1234, exp_ai_cnt = 16'h1122;
  logic [4*IDX_W-1:0]     di_first_q, dq_first_q, ai_first_q;
  logic [IDX_W-1:0]       ai_total_q, ai_sel_idx = '0;
  logic [BASE_DI-1:0]     base_pin = '0, base_di_q;
  logic                   prog_ai1_use = 1'b0, prog_ai2_use = 1'b0, ai_sel_ok;
  logic [AI_W-1:0]        adc_ai1 = '0, adc_ai2 = '0, analog_in1_q, analog_in2_q;
  int                     err_count = 0;
  int                     n_compared = 0;
  // Expected {and, nand, or, nor, xor, not} for input pattern equal to the row index
  logic [5:0]             exp_row [8] = '{6'h15, 6'h1A, 6'h1B, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h28};
  logic [5:0]             seen;

  always #12.5 clock = ~clock;

  bfb_core DUT (
    .clock(clock), .rst(rst),
    .and_in(and_in), .and_conn(and_conn), .andr_in(andr_in), .andr_conn(andr_conn),
    .nand_in(nand_in), .nand_conn(nand_conn), .nandf_in(nandf_in), .nandf_conn(nandf_conn),
    .or_in(or_in), .or_conn(or_conn), .nor_in(nor_in), .nor_conn(nor_conn),
    .xor_in(xor_in), .xor_conn(xor_conn), .not_in(not_in),
    .and_q(and_q), .and_rise_q(and_rise_q), .nand_q(nand_q), .nand_fall_q(nand_fall_q),
    .or_q(or_q), .nor_q(nor_q), .xor_q(xor_q), .not_q(not_q),
    .const_high(const_high), .const_low(const_low),
    .mark_in(mark_in), .mark_q(mark_q), .first_cycle_marker(first_cycle_marker),
    .add_req(add_req), .add_need(add_need), .add_offer(add_offer), .add_done_q(add_done_q),
    .add_refused_q(add_refused_q), .blk_count_q(blk_count_q), .mem_free_q(mem_free_q),
    .exp_di_cnt(exp_di_cnt), .exp_dq_cnt(exp_dq_cnt), .exp_ai_cnt(exp_ai_cnt),
    .di_first_q(di_first_q), .dq_first_q(dq_first_q), .ai_first_q(ai_first_q),
    .ai_total_q(ai_total_q), .base_pin(base_pin), .prog_ai1_use(prog_ai1_use),
    .prog_ai2_use(prog_ai2_use), .adc_ai1(adc_ai1), .adc_ai2(adc_ai2), .base_di_q(base_di_q),
    .analog_in1_q(analog_in1_q), .analog_in2_q(analog_in2_q), .ai_sel_idx(ai_sel_idx),
    .ai_sel_ok(ai_sel_ok)
  );

  task automatic final_report();
    $display("Compared %0d values, %0d mismatches", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Watchdog: the whole run is under a hundred cycles
  initial begin
    #(25 * 5000);
    err_count++;
    final_report();
  end

  initial begin
    cyc(3);
    `CHK("mark_q in reset", 8'h80, mark_q)
    rst = 1'b0;
    `CHK("first marker", 1'b1, first_cycle_marker)
    mark_in = 8'h5A;
    cyc(1);
    `CHK("first marker cleared", 1'b0, first_cycle_marker)
    `CHK("mark_q follows", 8'h5A, mark_q)
    mark_in = 8'hA5;
    #5;
    // Input moved mid-cycle, output must hold
    `CHK("mark_q steady", 8'h5A, mark_q)
    cyc(1);
    `CHK("mark_q bit7 normal", 8'hA5, mark_q)
    `CHK("const high", 1'b1, const_high)
    `CHK("const low", 1'b0, const_low)
    // Ordinary gate cases, all inputs connected
    for (int i = 0; i < 8; i++) begin
      {and_in, nand_in, or_in, nor_in} = {4{i[2:0]}};
      xor_in = i[1:0];
      not_in = i[0];
      cyc(1);
      seen = {and_q, nand_q, or_q, nor_q, xor_q, not_q};
      `CHK("gate row", exp_row[i], seen)
    end
    // Unconnected pins: AND side reads high, OR side reads low
    {and_conn, nand_conn, or_conn, nor_conn, xor_conn} = '0;
    {and_in, nand_in} = '0;
    {or_in, nor_in, xor_in} = '1;
    cyc(1);
    `CHK("open and", 1'b1, and_q)
    `CHK("open nand", 1'b0, nand_q)
    `CHK("open or", 1'b0, or_q)
    `CHK("open nor", 1'b1, nor_q)
    `CHK("open xor", 1'b0, xor_q)
    and_conn = 3'h1;
    xor_conn = 2'h1;
    cyc(1);
    `CHK("partial and", 1'b0, and_q)
    `CHK("partial xor", 1'b1, xor_q)
    // Edge blocks: prepare history
    andr_in = 3'h3;
    nandf_in = 3'h7;
    cyc(1);
    `CHK("rise idle", 1'b0, and_rise_q)
    andr_in = 3'h7;
    nandf_in = 3'h6;
    cyc(1);
    `CHK("rise pulse", 1'b1, and_rise_q)
    `CHK("fall pulse", 1'b1, nand_fall_q)
    cyc(1);
    `CHK("rise one cycle", 1'b0, and_rise_q)
    `CHK("fall one cycle", 1'b0, nand_fall_q)
    // Open third pin counts as high for the rising block
    andr_conn = 3'h3;
    andr_in = 3'h1;
    cyc(1);
    andr_in = 3'h3;
    cyc(1);
    `CHK("rise open pin", 1'b1, and_rise_q)
    // Block budget
    add_need = 8'h06;
    #1;
    `CHK("offer", 1'b1, add_offer)
    add_req = 1'b1;
    cyc(1);
    add_req = 1'b0;
    `CHK("add done", 1'b1, add_done_q)
    `CHK("count one", 6'h01, blk_count_q)
    `CHK("free 42", 8'h2A, mem_free_q)
    add_need = 8'h2B;
    #1;
    `CHK("no offer mem", 1'b0, add_offer)
    add_req = 1'b1;
    cyc(1);
    `CHK("refused mem", 1'b1, add_refused_q)
    `CHK("count kept", 6'h01, blk_count_q)
    // Back-to-back zero-size blocks up to the ceiling
    add_need = 8'h00;
    cyc(55);
    `CHK("count 56", 6'h38, blk_count_q)
    `CHK("no offer full", 1'b0, add_offer)
    cyc(1);
    add_req = 1'b0;
    `CHK("refused full", 1'b1, add_refused_q)
    `CHK("count held", 6'h38, blk_count_q)
    // Terminal numbering
    `CHK("di first", {7'd18, 7'd16, 7'd13, 7'd9}, di_first_q)
    `CHK("dq first", {7'd14, 7'd12, 7'd9, 7'd5}, dq_first_q)
    `CHK("ai first", {7'd8, 7'd7, 7'd5, 7'd3}, ai_first_q)
    `CHK("ai total", 7'd8, ai_total_q)
    foreach (exp_row[k]) begin
      ai_sel_idx = IDX_W'(k == 0 ? 0 : k + 2);
      #1;
      `CHK("ai select", (k > 0 && k < 7), ai_sel_ok)
    end
    // Base inputs: seventh as analog, eighth as digital
    base_pin = 8'hFF;
    prog_ai1_use = 1'b1;
    adc_ai1 = 10'h155;
    adc_ai2 = 10'h2AA;
    cyc(3);
    `CHK("base di", 8'hBF, base_di_q)
    `CHK("analog 1", 10'h155, analog_in1_q)
    `CHK("analog 2 unused", 10'h000, analog_in2_q)
    // Eighth pin taken as analog as well
    prog_ai2_use = 1'b1;
    cyc(1);
    `CHK("base di both analog", 8'h3F, base_di_q)
    `CHK("analog 2", 10'h2AA, analog_in2_q)
    // Program restart in mid-run
    rst = 1'b1;
    cyc(1);
    rst = 1'b0;
    `CHK("count cleared", 6'h00, blk_count_q)
    `CHK("free restored", 8'h30, mem_free_q)
    `CHK("first marker again", 1'b1, first_cycle_marker)
    `CHK("mark_q restart", 8'h80, mark_q)
    final_report();
  end
endmodule

`undef CHK
`default_nettype wire
